/* File: hw/csc_pkg.sv */
// constants for the battery-backed setup byte store
// assumes a single byte-wide indexed register port, 64 locations
package csc_pkg;

	localparam int CSC_DEPTH = 64;
	localparam int CSC_AW = 8;

	// byte offsets
	localparam logic [7:0] OFS_SEC = 8'h00;
	localparam logic [7:0] OFS_MIN = 8'h02;
	localparam logic [7:0] OFS_HOUR = 8'h04;
	localparam logic [7:0] OFS_DAY_OF_WEEK = 8'h06;
	localparam logic [7:0] OFS_DATE = 8'h07;
	localparam logic [7:0] OFS_MONTH = 8'h08;
	localparam logic [7:0] OFS_YEAR = 8'h09;
	localparam logic [7:0] OFS_FAULT = 8'h0E;
	localparam logic [7:0] OFS_SHUTDOWN = 8'h0F;
	localparam logic [7:0] OFS_FLOPPY = 8'h10;
	localparam logic [7:0] OFS_FIXED = 8'h12;
	localparam logic [7:0] OFS_EQUIP = 8'h14;
	localparam logic [7:0] OFS_BASE_LO = 8'h15;
	localparam logic [7:0] OFS_BASE_HI = 8'h16;
	localparam logic [7:0] OFS_EXT_LO = 8'h17;
	localparam logic [7:0] OFS_EXT_HI = 8'h18;
	localparam logic [7:0] OFS_OPTIONS = 8'h20;
	localparam logic [7:0] OFS_KBD = 8'h21;
	localparam logic [7:0] OFS_DISK2 = 8'h22;
	localparam logic [7:0] OFS_REBOOT = 8'h23;
	localparam logic [7:0] OFS_EXT_ALT_LO = 8'h30;
	localparam logic [7:0] OFS_EXT_ALT_HI = 8'h31;
	localparam logic [7:0] OFS_CENTURY = 8'h32;
	localparam logic [7:0] OFS_INFO = 8'h33;

	// field positions
	localparam int OPT_SER_HI = 7;
	localparam int OPT_SER_LO = 6;
	localparam int OPT_ENH = 5;
	localparam int OPT_BOOT_HI = 4;
	localparam int OPT_BOOT_LO = 3;
	localparam int OPT_NUMLOCK = 2;
	localparam int OPT_BEEP_HI = 1;
	localparam int OPT_BEEP_LO = 0;
	localparam int FLT_TIME = 2;
	localparam int INFO_MSG = 6;
	localparam int INFO_640 = 7;
	localparam logic [7:0] FAULT_MASK = 8'hFC;

	// codes
	localparam logic [3:0] FLOPPY_360K = 4'h1;
	localparam logic [3:0] FLOPPY_1M2 = 4'h2;
	localparam logic [3:0] DISK_TYPE_A = 4'h7;
	localparam logic [3:0] DISK_TYPE_B = 4'h9;
	localparam logic [1:0] SER_OFF = 2'h0;
	localparam logic [1:0] SER_PRI = 2'h1;
	localparam logic [1:0] SER_SEC = 2'h2;
	localparam logic [15:0] SER_PRI_BASE = 16'h03F8;
	localparam logic [15:0] SER_SEC_BASE = 16'h02F8;
	localparam logic [7:0] KBD_STD = 8'h00;
	localparam logic [7:0] KBD_OLD = 8'h10;
	localparam logic [7:0] KBD_NONE = 8'hFF;
	localparam logic [7:0] SHUT_MAX = 8'h0A;
	localparam logic [15:0] BASE_640K = 16'h0280;
	localparam logic [3:0] BCD_MAX = 4'h9;

	// values after reset
	localparam logic [7:0] RST_FLOPPY = 8'h20;
	localparam logic [7:0] RST_FIXED = 8'h70;
	localparam logic [7:0] RST_EQUIP = 8'h21;
	localparam logic [7:0] RST_BASE_LO = 8'h80;
	localparam logic [7:0] RST_BASE_HI = 8'h02;
	localparam logic [7:0] RST_CENTURY = 8'h19;
	localparam logic [7:0] RST_INFO = 8'h80;
	localparam logic [7:0] RST_ZERO = 8'h00;

endpackage : csc_pkg

/* File: hw/csc_store.sv */
// battery-backed setup byte store: 64 indexed bytes plus decoded fields
// assumes the fault event inputs come from logic on I_REF_CLK
//
// How it works
// [R1] time and date bytes hold packed BCD; a non-BCD write flags bad time; writes to day of week 06 and century 32 are not checked
// [R2] software clears both error bytes by writing zero
// [R3] floppy byte upper nibble is drive one: 1 is 360k, 2 is 1.2M
// [R4] fixed disk byte upper nibble is disk one; types 7 and 9 known
// [R5] second disk table byte holds the type for the alternative table, else zero
// [R6] installed hardware byte holds basic equipment, 21 after reset
// [R7] base memory word, low byte first, in kbytes; 0280 is 640k
// [R8] extended memory word, low byte first, kbytes above one megabyte
// [R9] serial field: 00 off, 01 port 03F8, 10 port 02F8
// [R10] option bit 5 is the enhancement switch
// [R11] option bits 4:3 pick boot: standard, second floppy, no floppy
// [R12] option bit 2 turns numeric lock on at startup
// [R13] option bits 1:0 give beep level: normal, high, off, low
// [R14] keyboard byte: 00 standard, 10 older type, FF none
// [R15] century byte extends the two-digit year
// [R16] information byte 80 means 640k; bit 6 flags first user message
// [R17] reboot key code lives at 23h, software sets it to 6Ah
// [R18] fault bits 7,6,5: power lost, bad checksum, bad equipment
// [R19] fault bits 4,3,2: memory mismatch, disk init, bad time; 1:0 reserved
// [R20] firmware reads the shutdown byte to choose where to resume
// [R21] shutdown codes run 0 to A; larger writes are dropped
// [R22] every byte keeps its value and is read and written by index
// [R23] reserved fault bits read zero and ignore writes
`timescale 1ns/10ps

module csc_store
	import csc_pkg::*;
(
	// clock and reset
	input wire logic I_REF_CLK,
	input wire logic I_RESET,
	input wire logic I_CLK_EN,
	// register port
	input wire logic [csc_pkg::CSC_AW-1:0] I_ADDR,
	input wire logic [7:0] I_WR_DATA,
	input wire logic I_WR_STB,
	input wire logic I_RD_STB,
	output logic [7:0] O_RD_DATA,
	// fault events
	input wire logic [7:0] I_FAULT_SET,
	// drives and equipment
	output logic [3:0] O_FLOPPY_KIND,
	output logic O_FLOPPY_360K,
	output logic O_FLOPPY_1M2,
	output logic [3:0] O_FIXED_DISK_KIND,
	output logic O_FIXED_DISK_KNOWN,
	output logic O_DISK_TABLE_ALT,
	output logic [7:0] O_EQUIPMENT,
	// memory sizes
	output logic [15:0] O_BASE_KB,
	output logic [15:0] O_EXT_KB,
	output logic O_BASE_640K,
	output logic O_FIRST_MSG,
	// options
	output logic [1:0] O_SERIAL_SEL,
	output logic [15:0] O_SERIAL_BASE,
	output logic O_ENHANCE_EN,
	output logic [1:0] O_BOOT_MODE,
	output logic O_NUMLOCK_ON,
	output logic [1:0] O_BEEP_LEVEL,
	output logic O_KBD_OLD,
	output logic O_KBD_NONE,
	// status
	output logic [7:0] O_CENTURY,
	output logic [7:0] O_FAULT_FLAGS,
	output logic [3:0] O_SHUTDOWN_CODE,
	output logic O_BOOT_BLOCKED,
	output logic [7:0] O_REBOOT_KEY
);
	import csc_pkg::*;

	// ****************************************
	// storage and address mapping
	// ****************************************

	logic [7:0] mem_r [0:CSC_DEPTH-1];
	logic [7:0] rd_data_r;
	logic in_range;
	logic [5:0] phys_idx;
	logic wr_en;
	logic rd_en;
	logic wr_bcd_bad;
	logic time_write;
	// fault and shutdown bytes have their own registers so each has one writer
	logic [7:0] fault_r;
	logic [7:0] fault_nxt;
	logic [7:0] shut_r;

	function automatic logic [7:0] reset_value(input int idx);
		logic [7:0] v;
		v = RST_ZERO;
		case (8'(idx))
			OFS_FLOPPY: v = RST_FLOPPY;
			OFS_FIXED: v = RST_FIXED;
			OFS_EQUIP: v = RST_EQUIP;
			OFS_BASE_LO: v = RST_BASE_LO;
			OFS_BASE_HI: v = RST_BASE_HI;
			OFS_CENTURY: v = RST_CENTURY;
			OFS_INFO: v = RST_INFO;
			default: v = RST_ZERO;
		endcase
		return v;
	endfunction

	function automatic logic is_bcd(input logic [7:0] v);
		return (v[7:4] <= BCD_MAX) && (v[3:0] <= BCD_MAX);
	endfunction

	// the extended size appears at two indices; one copy avoids disagreement
	always_comb begin
		phys_idx = I_ADDR[5:0];
		if (I_ADDR == OFS_EXT_ALT_LO) begin
			phys_idx = OFS_EXT_LO[5:0]; // [R8]
		end else if (I_ADDR == OFS_EXT_ALT_HI) begin
			phys_idx = OFS_EXT_HI[5:0]; // [R8]
		end
	end

	assign in_range = (I_ADDR < 8'(CSC_DEPTH));
	assign wr_en = I_CLK_EN && I_WR_STB && in_range;
	assign rd_en = I_CLK_EN && I_RD_STB;

	always_comb begin
		time_write = 1'b0;
		case (I_ADDR)
			OFS_SEC, OFS_MIN, OFS_HOUR: time_write = 1'b1; // [R1]
			OFS_DATE, OFS_MONTH, OFS_YEAR: time_write = 1'b1; // [R1]
			default: time_write = 1'b0;
		endcase
	end

	assign wr_bcd_bad = wr_en && time_write && !is_bcd(I_WR_DATA); // [R1]

	// ****************************************
	// byte writes
	// ****************************************

	// plain bytes: reset stands for loss of battery, otherwise bytes persist
	always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
		if (I_RESET) begin
			// the fault and shutdown slots stay at zero and are never read
			for (int i = 0; i < CSC_DEPTH; i++) begin
				mem_r[i] <= reset_value(i);
			end
		end else if (wr_en) begin
			if (phys_idx != OFS_FAULT[5:0] && phys_idx != OFS_SHUTDOWN[5:0]) begin
				mem_r[phys_idx] <= I_WR_DATA; // [R22] [R5] [R17] [R15]
			end
		end
	end

	// fault byte: a hardware set in the same cycle as a write wins
	always_comb begin
		fault_nxt = fault_r;
		if (wr_en && phys_idx == OFS_FAULT[5:0]) begin
			fault_nxt = I_WR_DATA; // [R2]
		end
		fault_nxt = fault_nxt | I_FAULT_SET; // [R18] [R19]
		fault_nxt[FLT_TIME] = fault_nxt[FLT_TIME] | wr_bcd_bad; // [R1] [R19]
		fault_nxt = fault_nxt & FAULT_MASK; // [R23]
	end

	always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
		if (I_RESET) begin
			fault_r <= RST_ZERO;
		end else if (I_CLK_EN) begin
			fault_r <= fault_nxt;
		end
	end

	// shutdown byte: out-of-range codes would send firmware nowhere valid
	always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
		if (I_RESET) begin
			shut_r <= RST_ZERO;
		end else if (wr_en && phys_idx == OFS_SHUTDOWN[5:0]) begin
			if (I_WR_DATA <= SHUT_MAX) begin
				shut_r <= I_WR_DATA; // [R21] [R2]
			end
		end
	end

	// ****************************************
	// read port
	// ****************************************

	// data stand one cycle after the strobe and read zero after other enabled cycles; they hold while I_CLK_EN is low
	always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
		if (I_RESET) begin
			rd_data_r <= RST_ZERO;
		end else if (I_CLK_EN) begin
			if (rd_en && in_range && phys_idx == OFS_FAULT[5:0]) begin
				rd_data_r <= fault_r; // [R22]
			end else if (rd_en && in_range && phys_idx == OFS_SHUTDOWN[5:0]) begin
				rd_data_r <= shut_r; // [R22]
			end else if (rd_en && in_range) begin
				rd_data_r <= mem_r[phys_idx]; // [R22]
			end else begin
				rd_data_r <= RST_ZERO;
			end
		end
	end

	assign O_RD_DATA = rd_data_r;

	// ****************************************
	// drive and equipment decode
	// ****************************************

	always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
		if (I_RESET) begin
			O_FLOPPY_KIND <= 4'h0;
			O_FLOPPY_360K <= 1'b0;
			O_FLOPPY_1M2 <= 1'b0;
		end else if (I_CLK_EN) begin
			O_FLOPPY_KIND <= mem_r[OFS_FLOPPY[5:0]][7:4]; // [R3]
			O_FLOPPY_360K <= mem_r[OFS_FLOPPY[5:0]][7:4] == FLOPPY_360K; // [R3]
			O_FLOPPY_1M2 <= mem_r[OFS_FLOPPY[5:0]][7:4] == FLOPPY_1M2; // [R3]
		end
	end

	always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
		if (I_RESET) begin
			O_FIXED_DISK_KIND <= 4'h0;
			O_FIXED_DISK_KNOWN <= 1'b0;
			O_DISK_TABLE_ALT <= 1'b0;
		end else if (I_CLK_EN) begin
			O_FIXED_DISK_KIND <= mem_r[OFS_FIXED[5:0]][7:4]; // [R4]
			O_FIXED_DISK_KNOWN <= (mem_r[OFS_FIXED[5:0]][7:4] == DISK_TYPE_A) ||
				(mem_r[OFS_FIXED[5:0]][7:4] == DISK_TYPE_B); // [R4]
			// zero means the maker's table is in use
			O_DISK_TABLE_ALT <= mem_r[OFS_DISK2[5:0]] != RST_ZERO; // [R5]
		end
	end

	always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
		if (I_RESET) begin
			O_EQUIPMENT <= RST_ZERO;
		end else if (I_CLK_EN) begin
			O_EQUIPMENT <= mem_r[OFS_EQUIP[5:0]]; // [R6]
		end
	end

	// ****************************************
	// memory sizes
	// ****************************************

	always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
		if (I_RESET) begin
			O_BASE_KB <= 16'h0000;
			O_BASE_640K <= 1'b0;
		end else if (I_CLK_EN) begin
			O_BASE_KB <= {mem_r[OFS_BASE_HI[5:0]], mem_r[OFS_BASE_LO[5:0]]}; // [R7]
			O_BASE_640K <= {mem_r[OFS_BASE_HI[5:0]], mem_r[OFS_BASE_LO[5:0]]} ==
				BASE_640K; // [R7]
		end
	end

	always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
		if (I_RESET) begin
			O_EXT_KB <= 16'h0000;
		end else if (I_CLK_EN) begin
			O_EXT_KB <= {mem_r[OFS_EXT_HI[5:0]], mem_r[OFS_EXT_LO[5:0]]}; // [R8]
		end
	end

	// information byte is software-owned; the block only reports its message bit 6
	always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
		if (I_RESET) begin
			O_FIRST_MSG <= 1'b0;
		end else if (I_CLK_EN) begin
			O_FIRST_MSG <= mem_r[OFS_INFO[5:0]][INFO_MSG]; // [R16]
		end
	end

	// ****************************************
	// option flags
	// ****************************************

	always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
		if (I_RESET) begin
			O_SERIAL_SEL <= SER_OFF;
			O_SERIAL_BASE <= 16'h0000;
		end else if (I_CLK_EN) begin
			O_SERIAL_SEL <= mem_r[OFS_OPTIONS[5:0]][OPT_SER_HI:OPT_SER_LO]; // [R9]
			case (mem_r[OFS_OPTIONS[5:0]][OPT_SER_HI:OPT_SER_LO])
				SER_PRI: O_SERIAL_BASE <= SER_PRI_BASE; // [R9]
				SER_SEC: O_SERIAL_BASE <= SER_SEC_BASE; // [R9]
				default: O_SERIAL_BASE <= 16'h0000;
			endcase
		end
	end

	always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
		if (I_RESET) begin
			O_ENHANCE_EN <= 1'b0;
			O_BOOT_MODE <= 2'h0;
			O_NUMLOCK_ON <= 1'b0;
			O_BEEP_LEVEL <= 2'h0;
		end else if (I_CLK_EN) begin
			O_ENHANCE_EN <= mem_r[OFS_OPTIONS[5:0]][OPT_ENH]; // [R10]
			O_BOOT_MODE <= mem_r[OFS_OPTIONS[5:0]][OPT_BOOT_HI:OPT_BOOT_LO]; // [R11]
			O_NUMLOCK_ON <= mem_r[OFS_OPTIONS[5:0]][OPT_NUMLOCK]; // [R12]
			O_BEEP_LEVEL <= mem_r[OFS_OPTIONS[5:0]][OPT_BEEP_HI:OPT_BEEP_LO]; // [R13]
		end
	end

	always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
		if (I_RESET) begin
			O_KBD_OLD <= 1'b0;
			O_KBD_NONE <= 1'b0;
		end else if (I_CLK_EN) begin
			O_KBD_OLD <= mem_r[OFS_KBD[5:0]] == KBD_OLD; // [R14]
			O_KBD_NONE <= mem_r[OFS_KBD[5:0]] == KBD_NONE; // [R14]
		end
	end

	// ****************************************
	// status bytes
	// ****************************************

	always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
		if (I_RESET) begin
			O_CENTURY <= RST_ZERO;
			O_REBOOT_KEY <= RST_ZERO;
		end else if (I_CLK_EN) begin
			O_CENTURY <= mem_r[OFS_CENTURY[5:0]]; // [R15]
			O_REBOOT_KEY <= mem_r[OFS_REBOOT[5:0]]; // [R17]
		end
	end

	// boot stays blocked until software zeroes both error bytes
	always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
		if (I_RESET) begin
			O_FAULT_FLAGS <= RST_ZERO;
			O_SHUTDOWN_CODE <= 4'h0;
			O_BOOT_BLOCKED <= 1'b0;
		end else if (I_CLK_EN) begin
			O_FAULT_FLAGS <= fault_r; // [R18] [R19]
			O_SHUTDOWN_CODE <= shut_r[3:0]; // [R20] [R21]
			O_BOOT_BLOCKED <= (fault_r != RST_ZERO) || (shut_r != RST_ZERO); // [R2]
		end
	end

endmodule // csc_store

/* File: tb/csc_props.sv */
// concurrent checks on the setup byte store ports
// assumes it is bound into csc_store and sees nothing but its ports
`timescale 1ns/10ps
module csc_props
	import csc_pkg::*;
(
	// clock and reset
	input logic I_REF_CLK,
	input logic I_RESET,
	input logic I_CLK_EN,
	// register port
	input logic [CSC_AW-1:0] I_ADDR,
	input logic [7:0] I_WR_DATA,
	input logic I_WR_STB,
	input logic I_RD_STB,
	input logic [7:0] O_RD_DATA,
	// status and decoded fields
	input logic [7:0] I_FAULT_SET,
	input logic [7:0] O_FAULT_FLAGS,
	input logic [3:0] O_SHUTDOWN_CODE,
	input logic O_BOOT_BLOCKED,
	input logic [1:0] O_SERIAL_SEL,
	input logic [15:0] O_SERIAL_BASE,
	input logic [3:0] O_FIXED_DISK_KIND,
	input logic O_FIXED_DISK_KNOWN,
	input logic [15:0] O_BASE_KB,
	input logic O_BASE_640K
);
	// ****
	// assertions
	// ****
	default clocking cb @(posedge I_REF_CLK);
	endclocking
	default disable iff (I_RESET);
	rd_idle_a: assert property (I_CLK_EN && !I_RD_STB |=> O_RD_DATA == 8'h00)
		else $error("read data not cleared");
	rd_unmap_a: assert property (I_CLK_EN && I_RD_STB && I_ADDR >= 8'h40
		|=> O_RD_DATA == 8'h00) else $error("unmapped read not zero");
	key_echo_a: assert property ((I_CLK_EN && I_WR_STB && I_ADDR == OFS_REBOOT)
		##1 (I_CLK_EN && I_RD_STB && I_ADDR == OFS_REBOOT)
		|=> O_RD_DATA == $past(I_WR_DATA, 2)) else $error("key code not read back");
	fault_rsv_a: assert property (O_FAULT_FLAGS[1:0] == 2'h0)
		else $error("reserved fault bits set");
	fault_set_a: assert property ((I_CLK_EN && I_FAULT_SET[7]) ##1 I_CLK_EN
		|=> O_FAULT_FLAGS[7]) else $error("power loss flag not set");
	boot_blk_a: assert property (O_BOOT_BLOCKED == (|O_FAULT_FLAGS || |O_SHUTDOWN_CODE))
		else $error("boot block wrong");
	ser_base_a: assert property (O_SERIAL_BASE == ((O_SERIAL_SEL == SER_PRI) ? SER_PRI_BASE
		: (O_SERIAL_SEL == SER_SEC) ? SER_SEC_BASE : 16'h0000)) else $error("serial base wrong");
	disk_known_a: assert property (O_FIXED_DISK_KNOWN == (O_FIXED_DISK_KIND == 4'h7
		|| O_FIXED_DISK_KIND == 4'h9)) else $error("disk type decode wrong");
	base_640_a: assert property (O_BASE_640K == (O_BASE_KB == 16'h0280))
		else $error("640k flag wrong");
	cover property (I_CLK_EN && I_RD_STB && I_ADDR >= 8'h40);
	cover property (O_BOOT_BLOCKED);
	cover property (I_CLK_EN && I_FAULT_SET[7]);
endmodule // csc_props

bind csc_store csc_props u_props (.I_REF_CLK(I_REF_CLK), .I_RESET(I_RESET),
	.I_CLK_EN(I_CLK_EN), .I_ADDR(I_ADDR), .I_WR_DATA(I_WR_DATA), .I_WR_STB(I_WR_STB),
	.I_RD_STB(I_RD_STB), .O_RD_DATA(O_RD_DATA), .I_FAULT_SET(I_FAULT_SET),
	.O_FAULT_FLAGS(O_FAULT_FLAGS), .O_SHUTDOWN_CODE(O_SHUTDOWN_CODE),
	.O_BOOT_BLOCKED(O_BOOT_BLOCKED), .O_SERIAL_SEL(O_SERIAL_SEL),
	.O_SERIAL_BASE(O_SERIAL_BASE), .O_FIXED_DISK_KIND(O_FIXED_DISK_KIND),
	.O_FIXED_DISK_KNOWN(O_FIXED_DISK_KNOWN), .O_BASE_KB(O_BASE_KB), .O_BASE_640K(O_BASE_640K));

/* File: tb/cmos_setup_config_store_test.sv */
// self-checking bench for the setup byte store
// assumes csc_pkg, csc_store and the bound checker are compiled first
`timescale 1ns/10ps
module cmos_setup_config_store_test;
	import csc_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic en = 1'b1;
	logic ws = 1'b0;
	logic rs = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [7:0] wd = 8'h00;
	logic [7:0] fs = 8'h00;
	logic [7:0] rdd, equ, cen, flt, key;
	logic [3:0] fk, hk, sc;
	logic [1:0] ss, bm, bl;
	logic [15:0] bkb, xkb, sb;
	logic f36, f12, hkn, alt, b64, fm, enh, nl, ko, kn, bb;
	logic [7:0] q[$];
	logic rp = 1'b0;
	int mismatches = 0;
	int samples_checked = 0;
	int cyc = 0;
	logic [31:0] lr = 32'h00013EA1;

	always #20 clk = ~clk;

	csc_store dut (.I_REF_CLK(clk), .I_RESET(rst), .I_CLK_EN(en), .I_ADDR(adr),
		.I_WR_DATA(wd), .I_WR_STB(ws), .I_RD_STB(rs), .O_RD_DATA(rdd), .I_FAULT_SET(fs),
		.O_FLOPPY_KIND(fk), .O_FLOPPY_360K(f36), .O_FLOPPY_1M2(f12), .O_FIXED_DISK_KIND(hk),
		.O_FIXED_DISK_KNOWN(hkn), .O_DISK_TABLE_ALT(alt), .O_EQUIPMENT(equ), .O_BASE_KB(bkb),
		.O_EXT_KB(xkb), .O_BASE_640K(b64), .O_FIRST_MSG(fm), .O_SERIAL_SEL(ss),
		.O_SERIAL_BASE(sb), .O_ENHANCE_EN(enh), .O_BOOT_MODE(bm), .O_NUMLOCK_ON(nl),
		.O_BEEP_LEVEL(bl), .O_KBD_OLD(ko), .O_KBD_NONE(kn), .O_CENTURY(cen),
		.O_FAULT_FLAGS(flt), .O_SHUTDOWN_CODE(sc), .O_BOOT_BLOCKED(bb), .O_REBOOT_KEY(key));

	// ****
	// checking
	// ****
	task automatic ch(input logic [15:0] g, input logic [15:0] e);
		samples_checked++;
		if (g !== e) begin
			mismatches++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask

	task automatic final_report();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// read answers stand one cycle after the strobe is taken
	always @(posedge clk) begin
		if (rp) ch(16'(rdd), 16'(q.pop_front()));
		rp <= rs && en && !rst;
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			mismatches++;
			final_report();
		end
	end

	// ****
	// stimulus
	// ****
	function automatic logic [31:0] lf(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	function automatic logic [7:0] rv(input logic [7:0] a);
		case (a)
			OFS_FLOPPY: return 8'h20;
			OFS_FIXED: return 8'h70;
			OFS_EQUIP: return 8'h21;
			OFS_BASE_LO: return 8'h80;
			OFS_BASE_HI: return 8'h02;
			OFS_CENTURY: return 8'h19;
			OFS_INFO: return 8'h80;
			default: return 8'h00;
		endcase
	endfunction

	task automatic op(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		ws <= w;
		rs <= r;
		adr <= a;
		wd <= d;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		op(1'b1, 1'b0, a, d);
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		q.push_back(e);
		op(1'b0, 1'b1, a, 8'h00);
	endtask

	// decoded outputs trail the byte by one cycle
	task automatic settle();
		op(1'b0, 1'b0, 8'h00, 8'h00);
		@(posedge clk);
		@(negedge clk);
	endtask

	initial begin
		logic [7:0] d;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 66; i++) rd(8'(i), (i < 64) ? rv(8'(i)) : 8'h00);
		wr(8'h7F, 8'h55);
		rd(8'h3F, 8'h00);
		settle();
		ch(16'({f36, f12, hkn, b64, fk, hk}), 16'({4'h7, FLOPPY_1M2, DISK_TYPE_A}));
		ch({equ, cen}, 16'h2119);
		ch(bkb, 16'h0280);
		for (int i = 8'h24; i < 8'h2C; i++) begin
			lr = lf(lr);
			wr(8'(i), lr[7:0]);
			rd(8'(i), lr[7:0]);
		end
		wr(OFS_REBOOT, 8'h6A);
		rd(OFS_REBOOT, 8'h6A);
		for (int i = 0; i < 4; i++) begin
			d = {i[1:0], i[0], i[1:0], i[1], i[1:0]};
			wr(OFS_OPTIONS, d);
			settle();
			ch(16'({ss, enh, bm, nl, bl}), 16'(d));
			ch(sb, (i == 1) ? SER_PRI_BASE : (i == 2) ? SER_SEC_BASE : 16'h0000);
		end
		ch(16'(key), 16'h006A);
		wr(OFS_FLOPPY, 8'h15);
		wr(OFS_FIXED, 8'h93);
		wr(OFS_DISK2, 8'h09);
		wr(OFS_KBD, KBD_OLD);
		settle();
		ch(16'({f36, f12, hkn, alt, ko, kn, fk, hk}), 16'({6'h2E, FLOPPY_360K, DISK_TYPE_B}));
		wr(OFS_FIXED, 8'h50);
		wr(OFS_DISK2, 8'h00);
		wr(OFS_KBD, KBD_NONE);
		settle();
		ch(16'({hkn, alt, ko, kn}), 16'h0001);
		lr = lf(lr);
		wr(OFS_BASE_LO, 8'h00);
		wr(OFS_BASE_HI, 8'h02);
		wr(OFS_EXT_LO, lr[7:0]);
		wr(OFS_EXT_HI, lr[15:8]);
		wr(OFS_INFO, 8'hC0);
		wr(OFS_CENTURY, 8'h20);
		wr(OFS_KBD, KBD_STD);
		rd(OFS_EXT_ALT_HI, lr[15:8]);
		settle();
		ch(bkb, 16'h0200);
		ch(xkb, lr[15:0]);
		ch(16'({b64, fm, ko, kn, cen}), 16'h0420);
		for (int i = 0; i <= 8'h0A; i++) begin
			wr(OFS_SHUTDOWN, 8'(i));
			rd(OFS_SHUTDOWN, 8'(i));
		end
		wr(OFS_SHUTDOWN, 8'h0B);
		rd(OFS_SHUTDOWN, 8'h0A);
		settle();
		ch(16'({bb, sc}), 16'h001A);
		wr(OFS_FAULT, 8'hFF);
		rd(OFS_FAULT, 8'hFC);
		wr(OFS_FAULT, 8'h00);
		wr(OFS_SHUTDOWN, 8'h00);
		settle();
		ch(16'({bb, flt}), 16'h0000);
		// strobes drop before each event so a held write cannot clear the flag
		for (int b = 2; b < 8; b++) begin
			op(1'b0, 1'b0, 8'h00, 8'h00);
			fs <= 8'h03 | (8'h01 << b);
			@(posedge clk);
			fs <= 8'h00;
			rd(OFS_FAULT, 8'h01 << b);
			wr(OFS_FAULT, 8'h00);
		end
		wr(OFS_SEC, 8'h59);
		rd(OFS_FAULT, 8'h00);
		wr(OFS_MIN, 8'h5A);
		rd(OFS_FAULT, 8'h04);
		// a write while disabled must leave the byte alone
		op(1'b0, 1'b0, 8'h00, 8'h00);
		en <= 1'b0;
		wr(8'h3A, 8'h77);
		op(1'b0, 1'b0, 8'h00, 8'h00);
		@(posedge clk);
		en <= 1'b1;
		rd(8'h3A, 8'h00);
		// strobes are idle across the mid-run reset
		op(1'b0, 1'b0, 8'h00, 8'h00);
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rd(OFS_OPTIONS, 8'h00);
		rd(OFS_FLOPPY, 8'h20);
		settle();
		ch(16'(q.size()), 16'h0000);
		final_report();
	end
endmodule // cmos_setup_config_store_test
